// ---- hw/dgpl_pkg.sv ----
// Shared constants and types for the get/put list transfer engine
package dgpl_pkg;
  // Fixed widths
  localparam int LS_AW    = 18;            // Local storage byte address width
  localparam int EA_W     = 64;            // Effective and real address width
  localparam int TAG_W    = 5;             // Tag group id width
  localparam int CLS_W    = 8;             // Cache class id width
  localparam int SIZE_W   = 15;            // Byte count and list byte count width
  localparam int DATA_W   = 32;            // Word moved per beat
  // Step sizes
  localparam logic [SIZE_W-1:0] WORD_BYTES = 15'h0004; // Bytes per beat
  localparam logic [SIZE_W-1:0] ELEM_BYTES = 15'h0008; // Bytes per list element
  localparam logic [LS_AW-1:0]  LS_WORD    = 18'h00004; // Local address step
  localparam logic [EA_W-1:0]   EA_WORD    = 64'h0000_0000_0000_0004;
  localparam logic [LS_AW-1:0]  LS_ELEM    = 18'h00008;
  // Largest list the architecture allows, and what this engine supports
  localparam int LIST_ARCH_MAX  = 16384;
  localparam logic [SIZE_W-1:0] LIST_IMPL_MAX = 15'h4000;
  // List element first word layout, counted from the lsb
  localparam int EL_STALL_BIT = 31;        // Stall flag
  localparam int EL_CNT_MSB   = 14;        // Element byte count is [14:0]
  // Alignment masks
  localparam logic [2:0] ALIGN8_MASK = 3'h7;
  // Issuer register byte offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_TAG    = 5'h04;
  localparam logic [4:0] REG_SIZE   = 5'h08;
  localparam logic [4:0] REG_LSA    = 5'h0c;
  localparam logic [4:0] REG_EAH    = 5'h10;
  localparam logic [4:0] REG_EAL    = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  // CTRL field positions
  localparam int CT_PUT = 0;
  localparam int CT_LIST = 1;
  localparam int CT_FENCE = 2;
  localparam int CT_BARRIER = 3;
  localparam int CT_START = 4;
  localparam int CT_RESULT = 5;
  localparam int CT_PROXY = 6;
  localparam int CT_EAHV = 7;
  localparam int CT_GO = 31;
  // STATUS field positions
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_REJ = 2;
  localparam int ST_STALL = 3;
  localparam int ST_RUN = 4;
  localparam int ST_STAG = 8;
  localparam int ST_DTAG = 16;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

  // One command as it crosses between the ends
  typedef struct packed {
    logic              put;       // 0 get, 1 put
    logic              list;
    logic              fence;
    logic              barrier;
    logic              start;
    logic              result;
    logic              proxy;     // Came from the proxy queue
    logic              eah_vld;   // High word supplied
    logic [TAG_W-1:0]  tag_group_id;
    logic [CLS_W-1:0]  cache_class_id;
    logic [SIZE_W-1:0] byte_count;  // Or list byte count for lists
    logic [LS_AW-1:0]  local_store_addr;
    logic [31:0]       high_ea_word;
    logic [31:0]       low_ea_word;  // Or list start address for lists
  } dgpl_cmd_t;
endpackage

// ---- hw/dgpl_if.sv ----
// Command, completion and stall link between issuer and transfer controller
`timescale 1ns/10ps
interface dgpl_if;
  import dgpl_pkg::*;
  logic             cmd_valid;
  logic             cmd_ready;
  dgpl_cmd_t        cmd;
  logic             done_valid;
  logic             done_err;
  logic [TAG_W-1:0] done_tag;
  logic             stall_evt;
  logic [TAG_W-1:0] stall_tag;
  logic             stall_ack;
  logic             run_set;

  modport dev (input cmd_valid, cmd, stall_ack,
               output cmd_ready, done_valid, done_err, done_tag, stall_evt, stall_tag, run_set);
  modport iss (output cmd_valid, cmd, stall_ack,
               input cmd_ready, done_valid, done_err, done_tag, stall_evt, stall_tag, run_set);
endinterface

// ---- hw/dgpl_issuer.sv ----
// Command issuer end: software registers over Avalon-MM feeding the link
`timescale 1ns/10ps
module dgpl_issuer
  import dgpl_pkg::*;
(
  input  wire logic        clk_i,            // 40 MHz clock
  input  wire logic        reset_i,          // Sync reset, active high
  input  wire logic        ce_i,             // Clock enable
  input  wire logic [4:0]  avs_address_i,    // Byte address
  input  wire logic        avs_read_i,       // Read strobe
  input  wire logic        avs_write_i,      // Write strobe
  input  wire logic [31:0] avs_writedata_i,  // Write data
  output logic      [31:0] avs_readdata_o,   // Read data
  output logic             avs_waitrequest_o, // Low for one cycle per access
  dgpl_if.iss              lnk               // Link to the controller
);
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] ctrl_q, ctrl_d, tag_q, tag_d, size_q, size_d, lsa_q, lsa_d, eah_q, eah_d, eal_q, eal_d;
  logic        vld_q, vld_d, busy_q, busy_d, err_q, err_d, rej_q, rej_d;
  logic        stl_q, stl_d, run_q, run_d, ack_q, ack_d;
  logic [TAG_W-1:0] stag_q, stag_d, dtag_q, dtag_d;
  logic        acc, wr, legal;
  logic [31:0] status;

  // Local refusal of commands the queue may not carry
  always_comb begin
    legal = 1'b1;
    if (avs_writedata_i[CT_START] && !avs_writedata_i[CT_PROXY]) begin
      legal = 1'b0;
    end
    if (avs_writedata_i[CT_LIST]) begin
      if (avs_writedata_i[CT_PROXY]) begin
        legal = 1'b0;
      end
      if ((size_q[2:0] & ALIGN8_MASK) != 3'h0 || (eal_q[2:0] & ALIGN8_MASK) != 3'h0) begin
        legal = 1'b0;
      end
      if (size_q[SIZE_W-1:0] > LIST_IMPL_MAX) begin
        legal = 1'b0;
      end
    end
  end

  assign status = {11'h000, dtag_q, 3'h0, stag_q, 3'h0, run_q, stl_q, rej_q, err_q, busy_q};

  // Register file, link driving and status capture
  always_comb begin
    acc = (avs_read_i || avs_write_i) && !wait_q;
    wr = acc && avs_write_i;
    wait_d = !((avs_read_i || avs_write_i) && wait_q);
    rdata_d = rdata_q;
    ctrl_d = ctrl_q; tag_d = tag_q; size_d = size_q; lsa_d = lsa_q; eah_d = eah_q; eal_d = eal_q;
    vld_d = vld_q; busy_d = busy_q; err_d = err_q; rej_d = rej_q; stl_d = stl_q; run_d = run_q;
    stag_d = stag_q; dtag_d = dtag_q;
    ack_d = 1'b0;
    if ((avs_read_i || avs_write_i) && wait_q && avs_read_i) begin
      case (avs_address_i)
        REG_CTRL:   rdata_d = ctrl_q;
        REG_TAG:    rdata_d = tag_q;
        REG_SIZE:   rdata_d = size_q;
        REG_LSA:    rdata_d = lsa_q;
        REG_EAH:    rdata_d = eah_q;
        REG_EAL:    rdata_d = eal_q;
        REG_STATUS: rdata_d = status;
        default:    rdata_d = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
    if (lnk.cmd_valid && lnk.cmd_ready) begin
      vld_d = 1'b0;
    end
    if (wr) begin
      case (avs_address_i)
        REG_CTRL: begin
          ctrl_d = {1'b0, avs_writedata_i[30:0]};
          if (avs_writedata_i[CT_GO] && !busy_q) begin
            if (legal) begin
              vld_d = 1'b1;
              busy_d = 1'b1;
            end else begin
              rej_d = 1'b1;
            end
          end
        end
        REG_TAG:    tag_d = avs_writedata_i;
        REG_SIZE:   size_d = avs_writedata_i;
        REG_LSA:    lsa_d = avs_writedata_i;
        REG_EAH:    eah_d = avs_writedata_i;
        REG_EAL:    eal_d = avs_writedata_i;
        REG_STATUS: begin
          // Write one to clear; a stall arriving now still wins
          if (avs_writedata_i[ST_STALL] && stl_q) begin
            stl_d = 1'b0;
            ack_d = 1'b1;
          end
          if (avs_writedata_i[ST_ERR]) err_d = 1'b0;
          if (avs_writedata_i[ST_REJ]) rej_d = 1'b0;
          if (avs_writedata_i[ST_RUN]) run_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (lnk.stall_evt) begin
      stl_d = 1'b1;
      stag_d = lnk.stall_tag;
    end
    if (lnk.run_set) run_d = 1'b1;
    if (lnk.done_valid) begin
      busy_d = 1'b0;
      err_d = lnk.done_err;
      dtag_d = lnk.done_tag;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_q <= 1'b1; rdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST; tag_q <= 32'h0; size_q <= 32'h0; lsa_q <= 32'h0; eah_q <= 32'h0; eal_q <= 32'h0;
      vld_q <= 1'b0; busy_q <= 1'b0; err_q <= 1'b0; rej_q <= 1'b0; stl_q <= 1'b0; run_q <= 1'b0;
      stag_q <= '0; dtag_q <= '0; ack_q <= 1'b0;
    end else if (ce_i) begin
      wait_q <= wait_d; rdata_q <= rdata_d;
      ctrl_q <= ctrl_d; tag_q <= tag_d; size_q <= size_d; lsa_q <= lsa_d; eah_q <= eah_d; eal_q <= eal_d;
      vld_q <= vld_d; busy_q <= busy_d; err_q <= err_d; rej_q <= rej_d; stl_q <= stl_d; run_q <= run_d;
      stag_q <= stag_d; dtag_q <= dtag_d; ack_q <= ack_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign lnk.cmd_valid = vld_q;
  assign lnk.stall_ack = ack_q;
  // Command fields come straight from the held registers
  assign lnk.cmd = '{put: ctrl_q[CT_PUT], list: ctrl_q[CT_LIST], fence: ctrl_q[CT_FENCE],
                     barrier: ctrl_q[CT_BARRIER], start: ctrl_q[CT_START], result: ctrl_q[CT_RESULT],
                     proxy: ctrl_q[CT_PROXY], eah_vld: ctrl_q[CT_EAHV], tag_group_id: tag_q[TAG_W-1:0],
                     cache_class_id: tag_q[8+CLS_W-1:8], byte_count: size_q[SIZE_W-1:0],
                     local_store_addr: lsa_q[LS_AW-1:0], high_ea_word: eah_q, low_ea_word: eal_q};
endmodule // dgpl_issuer

// ---- hw/dgpl_controller.sv ----
// Transfer controller end: executes get/put and list commands one at a time
`timescale 1ns/10ps
module dgpl_controller
  import dgpl_pkg::*;
(
  input  wire logic              clk_i,       // 40 MHz clock
  input  wire logic              reset_i,     // Sync reset, active high
  input  wire logic              ce_i,        // Clock enable
  dgpl_if.dev                    lnk,         // Link to the issuer
  output logic                   xl_req_o,    // Translation request, held to ack
  output logic      [EA_W-1:0]   xl_ea_o,     // Effective address to translate
  input  wire logic              xl_ack_i,    // Translation done
  input  wire logic [EA_W-1:0]   xl_ra_i,     // Real address, valid with ack
  output logic                   ls_req_o,    // Local storage request, held to ack
  output logic                   ls_we_o,     // Local storage write
  output logic      [LS_AW-1:0]  ls_addr_o,   // Local storage byte address
  output logic      [DATA_W-1:0] ls_wdata_o,  // Local storage write data
  input  wire logic              ls_ack_i,    // Local storage done
  input  wire logic [DATA_W-1:0] ls_rdata_i,  // Local read data, valid with ack
  output logic                   bus_req_o,   // System bus request, held to ack
  output logic                   bus_we_o,    // System bus write
  output logic      [EA_W-1:0]   bus_addr_o,  // Real address
  output logic      [DATA_W-1:0] bus_wdata_o, // Bus write data
  input  wire logic              bus_ack_i,   // Bus done
  input  wire logic [DATA_W-1:0] bus_rdata_i  // Bus read data, valid with ack
);
  typedef enum logic [3:0] {S_IDLE, S_ORDER, S_LFETCH, S_XLATE, S_SRC, S_DST, S_NEXT, S_STALL,
                            S_DONE} dgpl_state_t;

  dgpl_state_t      st_q, st_d;
  dgpl_cmd_t        cmd_q, cmd_d;
  logic [EA_W-1:0]  ea_q, ea_d, ra_q, ra_d;
  logic [LS_AW-1:0] lsa_q, lsa_d, la_q, la_d;
  logic [SIZE_W-1:0] rem_q, rem_d, lrem_q, lrem_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic             half_q, half_d, stlf_q, stlf_d, err_q, err_d;
  logic [(1<<TAG_W)-1:0] tbusy_q, tbusy_d;
  logic             rdy_q, rdy_d, done_q, done_d, run_q, run_d, sev_q, sev_d;
  logic             xreq_q, xreq_d, lreq_q, lreq_d, lwe_q, lwe_d, breq_q, breq_d, bwe_q, bwe_d;
  logic [LS_AW-1:0] laddr_q, laddr_d;
  logic [EA_W-1:0]  baddr_q, baddr_d;
  logic [31:0]      hi_w;

  // Absent high word reads as zero
  assign hi_w = cmd_q.eah_vld ? cmd_q.high_ea_word : 32'h0000_0000;

  // Next state and every registered output
  always_comb begin
    st_d = st_q; cmd_d = cmd_q; ea_d = ea_q; ra_d = ra_q; lsa_d = lsa_q; la_d = la_q;
    rem_d = rem_q; lrem_d = lrem_q; data_d = data_q; half_d = half_q; stlf_d = stlf_q;
    err_d = err_q; tbusy_d = tbusy_q;
    done_d = 1'b0; run_d = 1'b0; sev_d = 1'b0; rdy_d = 1'b0;
    xreq_d = xreq_q; lreq_d = lreq_q; lwe_d = lwe_q; breq_d = breq_q; bwe_d = bwe_q;
    laddr_d = laddr_q; baddr_d = baddr_q;
    case (st_q)
      S_IDLE: begin
        rdy_d = 1'b1;
        if (lnk.cmd_valid && rdy_q) begin
          rdy_d = 1'b0;
          cmd_d = lnk.cmd;
          err_d = 1'b0;
          lsa_d = lnk.cmd.local_store_addr;
          if (lnk.cmd.start && !lnk.cmd.proxy) begin
            err_d = 1'b1;
            st_d = S_DONE;
          end else if (lnk.cmd.list && (lnk.cmd.proxy || lnk.cmd.byte_count > LIST_IMPL_MAX)) begin
            err_d = 1'b1;
            st_d = S_DONE;
          end else begin
            st_d = S_ORDER;
          end
        end
      end
      S_ORDER: begin
        // Fence and barrier wait for their tag group to drain
        if (!((cmd_q.fence || cmd_q.barrier) && tbusy_q[cmd_q.tag_group_id])) begin
          tbusy_d[cmd_q.tag_group_id] = 1'b1;
          if (cmd_q.list) begin
            la_d = cmd_q.low_ea_word[LS_AW-1:0];
            lrem_d = cmd_q.byte_count;
            half_d = 1'b0;
            lreq_d = 1'b1;
            lwe_d = 1'b0;
            laddr_d = cmd_q.low_ea_word[LS_AW-1:0];
            st_d = S_LFETCH;
          end else begin
            ea_d = {hi_w, cmd_q.low_ea_word};
            rem_d = cmd_q.byte_count;
            stlf_d = 1'b0;
            xreq_d = 1'b1;
            st_d = S_XLATE;
          end
        end
      end
      S_LFETCH: begin
        // Two local words per element, fetched in list order
        if (ls_ack_i) begin
          if (!half_q) begin
            data_d = ls_rdata_i;
            half_d = 1'b1;
            laddr_d = la_q + LS_WORD;
          end else begin
            lreq_d = 1'b0;
            la_d = la_q + LS_ELEM;
            lrem_d = lrem_q - ELEM_BYTES;
            stlf_d = data_q[EL_STALL_BIT];
            rem_d = data_q[EL_CNT_MSB:0];
            ea_d = {hi_w, ls_rdata_i};
            if (data_q[EL_CNT_MSB:0] == '0) begin
              st_d = S_NEXT;
            end else begin
              xreq_d = 1'b1;
              st_d = S_XLATE;
            end
          end
        end
      end
      S_XLATE: begin
        // One translation per element; a page crossing inside it is not retranslated
        if (xl_ack_i) begin
          xreq_d = 1'b0;
          ra_d = xl_ra_i;
          st_d = S_SRC;
          if (cmd_q.put) begin
            lreq_d = 1'b1; lwe_d = 1'b0; laddr_d = lsa_q;
          end else begin
            breq_d = 1'b1; bwe_d = 1'b0; baddr_d = xl_ra_i;
          end
        end
      end
      S_SRC: begin
        if (cmd_q.put ? ls_ack_i : bus_ack_i) begin
          data_d = cmd_q.put ? ls_rdata_i : bus_rdata_i;
          st_d = S_DST;
          if (cmd_q.put) begin
            // Result hint gives no cache path; a normal bus write
            lreq_d = 1'b0; breq_d = 1'b1; bwe_d = 1'b1; baddr_d = ra_q;
          end else begin
            breq_d = 1'b0; lreq_d = 1'b1; lwe_d = 1'b1; laddr_d = lsa_q;
          end
        end
      end
      S_DST: begin
        if (cmd_q.put ? bus_ack_i : ls_ack_i) begin
          breq_d = 1'b0; lreq_d = 1'b0;
          ra_d = ra_q + EA_WORD;
          lsa_d = lsa_q + LS_WORD;
          rem_d = (rem_q > WORD_BYTES) ? rem_q - WORD_BYTES : '0;
          if (rem_q > WORD_BYTES) begin
            st_d = S_SRC;
            if (cmd_q.put) begin
              lreq_d = 1'b1; lwe_d = 1'b0; laddr_d = lsa_q + LS_WORD;
            end else begin
              breq_d = 1'b1; bwe_d = 1'b0; baddr_d = ra_q + EA_WORD;
            end
          end else begin
            st_d = S_NEXT;
          end
        end
      end
      S_NEXT: begin
        // Stall on the last element is ignored
        if (cmd_q.list && lrem_q != '0) begin
          if (stlf_q) begin
            sev_d = 1'b1;
            st_d = S_STALL;
          end else begin
            half_d = 1'b0; lreq_d = 1'b1; lwe_d = 1'b0; laddr_d = la_q;
            st_d = S_LFETCH;
          end
        end else begin
          st_d = S_DONE;
        end
      end
      S_STALL: begin
        if (lnk.stall_ack) begin
          half_d = 1'b0; lreq_d = 1'b1; lwe_d = 1'b0; laddr_d = la_q;
          st_d = S_LFETCH;
        end
      end
      S_DONE: begin
        // Run bit only after all local and bus writes have been acknowledged
        done_d = 1'b1;
        run_d = cmd_q.start && !err_q;
        if (!err_q) tbusy_d[cmd_q.tag_group_id] = 1'b0;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= S_IDLE; cmd_q <= '0; ea_q <= '0; ra_q <= '0; lsa_q <= '0; la_q <= '0;
      rem_q <= '0; lrem_q <= '0; data_q <= '0; half_q <= 1'b0; stlf_q <= 1'b0; err_q <= 1'b0;
      tbusy_q <= '0; rdy_q <= 1'b0; done_q <= 1'b0; run_q <= 1'b0; sev_q <= 1'b0;
      xreq_q <= 1'b0; lreq_q <= 1'b0; lwe_q <= 1'b0; breq_q <= 1'b0; bwe_q <= 1'b0;
      laddr_q <= '0; baddr_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d; cmd_q <= cmd_d; ea_q <= ea_d; ra_q <= ra_d; lsa_q <= lsa_d; la_q <= la_d;
      rem_q <= rem_d; lrem_q <= lrem_d; data_q <= data_d; half_q <= half_d; stlf_q <= stlf_d;
      err_q <= err_d; tbusy_q <= tbusy_d; rdy_q <= rdy_d; done_q <= done_d; run_q <= run_d;
      sev_q <= sev_d; xreq_q <= xreq_d; lreq_q <= lreq_d; lwe_q <= lwe_d; breq_q <= breq_d;
      bwe_q <= bwe_d; laddr_q <= laddr_d; baddr_q <= baddr_d;
    end
  end

  // All outputs straight from flops
  assign lnk.cmd_ready = rdy_q;
  assign lnk.done_valid = done_q;
  assign lnk.done_err = err_q;
  assign lnk.done_tag = cmd_q.tag_group_id;
  assign lnk.stall_evt = sev_q;
  assign lnk.stall_tag = cmd_q.tag_group_id;
  assign lnk.run_set = run_q;
  assign xl_req_o = xreq_q;
  assign xl_ea_o = ea_q;
  assign ls_req_o = lreq_q;
  assign ls_we_o = lwe_q;
  assign ls_addr_o = laddr_q;
  assign ls_wdata_o = data_q;
  assign bus_req_o = breq_q;
  assign bus_we_o = bwe_q;
  assign bus_addr_o = baddr_q;
  assign bus_wdata_o = data_q;
endmodule // dgpl_controller

// ---- tb/dgpl_sva.sv ----
// Link assertions for the get/put list engine, both ends joined
`timescale 1ns/10ps
module dgpl_sva
  import dgpl_pkg::*;
(
  input wire logic             clk_i,      // Clock
  input wire logic             reset_i,    // Sync reset
  input wire logic             cmd_valid,  // Command offered
  input wire logic             cmd_ready,  // Command taken
  input wire dgpl_cmd_t        cmd,        // Command fields
  input wire logic             done_valid, // Completion
  input wire logic             done_err,   // Completion error
  input wire logic [TAG_W-1:0] done_tag,   // Completion tag
  input wire logic             stall_evt,  // Stall event
  input wire logic [TAG_W-1:0] stall_tag,  // Stall tag
  input wire logic             stall_ack,  // Stall acknowledge
  input wire logic             run_set     // Run bit pulse
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Steps of one command: offered, then finished cleanly
  sequence s_offer; $rose(cmd_valid); endsequence
  sequence s_good; done_valid && !done_err; endsequence
  a_run_after_done: assert property (
    run_set |-> s_good or ($past(done_valid) && !done_err)) else $error("run set without clean finish");
  a_run_from_proxy: assert property (
    run_set |-> cmd.start && cmd.proxy) else $error("run set by non-start command");
  a_start_refused: assert property (
    done_valid && cmd.start && !cmd.proxy |-> done_err) else $error("local start accepted");
  a_list_refused: assert property (
    done_valid && cmd.list && cmd.proxy |-> done_err) else $error("proxy list accepted");
  // The issuer must never offer what the queue may not carry
  a_start_offer_ok: assert property (
    cmd_valid |-> cmd.proxy || !cmd.start) else $error("local start offered");
  a_list_offer_ok: assert property (
    cmd_valid |-> !(cmd.list && cmd.proxy)) else $error("proxy list offered");
  a_list_align_ok: assert property (
    cmd_valid && cmd.list |-> cmd.byte_count[2:0] == 3'h0 && cmd.low_ea_word[2:0] == 3'h0)
    else $error("unaligned list offered");
  a_done_tag: assert property (
    done_valid |-> done_tag == cmd.tag_group_id) else $error("wrong finish tag");
  a_stall_tag: assert property (
    stall_evt |-> stall_tag == cmd.tag_group_id && cmd.list && !done_valid) else $error("bad stall");
  // A stalled list must not finish before its acknowledge
  a_stall_holds: assert property (
    stall_evt |=> !done_valid until stall_ack) else $error("finished while stalled");
  a_stall_bound: assert property (
    stall_evt |-> ##[1:1000] stall_ack) else $error("stall never acknowledged");
  a_done_bound: assert property (
    s_offer |-> ##[1:1000] done_valid) else $error("command never finished");
  a_one_done: assert property (
    done_valid |=> !done_valid) else $error("finish pulse too long");
endmodule // dgpl_sva

// ---- tb/dgpl_tb.sv ----
// Self-checking bench for the get/put list engine, both ends joined
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module dgpl_tb;
  import dgpl_pkg::*;
  localparam logic [EA_W-1:0] XM = 64'h0000_0100_0000_0000; // Bench translation
  localparam logic [7:0] MD [6] = '{8'h50, 8'h04, 8'h88, 8'h71, 8'h05, 8'hc9};
  localparam logic [7:0] RJ [3] = '{8'h10, 8'h42, 8'h02};
  logic              clk_i = 0, reset_i = 1, ce_i = 1, rd = 0, wr = 0, wt;
  logic [4:0]        adr = 0;
  logic [7:0]        c;
  logic [31:0]       wd = 0, rdat, ls_rd = 0, bus_rd = 0, q, wv, hi, lo, ls_wd, bus_wd;
  logic              xl_req, xl_ack = 0, ls_req, ls_we, ls_ack = 0, bus_req, bus_we, bus_ack = 0;
  logic [EA_W-1:0]   xl_ea, xl_ra = 0, bus_addr, ea;
  logic [LS_AW-1:0]  ls_addr, la, lst;
  logic [31:0]       ls_mem [logic [LS_AW-1:0]];
  logic [31:0]       bus_mem [logic [EA_W-1:0]];
  logic [31:0]       exq [$];
  int                fails = 0, checks = 0, seed = 32'h23fb91c6, nw;
  always #12.5 clk_i = ~clk_i;
  dgpl_if lnk ();
  dgpl_issuer u_dgpl_issuer (.clk_i, .reset_i, .ce_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .lnk(lnk));
  dgpl_controller u_dgpl_controller (.clk_i, .reset_i, .ce_i, .lnk(lnk), .xl_req_o(xl_req), .xl_ea_o(xl_ea),
    .xl_ack_i(xl_ack), .xl_ra_i(xl_ra), .ls_req_o(ls_req), .ls_we_o(ls_we), .ls_addr_o(ls_addr),
    .ls_wdata_o(ls_wd), .ls_ack_i(ls_ack), .ls_rdata_i(ls_rd), .bus_req_o(bus_req), .bus_we_o(bus_we),
    .bus_addr_o(bus_addr), .bus_wdata_o(bus_wd), .bus_ack_i(bus_ack), .bus_rdata_i(bus_rd));
  dgpl_sva u_sva (.clk_i, .reset_i, .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .cmd(lnk.cmd),
    .done_valid(lnk.done_valid), .done_err(lnk.done_err), .done_tag(lnk.done_tag), .stall_evt(lnk.stall_evt),
    .stall_tag(lnk.stall_tag), .stall_ack(lnk.stall_ack), .run_set(lnk.run_set));
  // Far side: random latency; idle data lines toggle so stale data never looks valid
  always @(posedge clk_i) begin
    xl_ack <= xl_req && !xl_ack && $random(seed) % 2 == 0;
    xl_ra <= xl_req ? xl_ea ^ XM : ~xl_ra;
    if (ls_req && !ls_ack && $random(seed) % 2 == 0) begin
      if (ls_we) ls_mem[ls_addr] = ls_wd;
      ls_ack <= 1;
      ls_rd <= ls_mem[ls_addr];
    end else begin
      ls_ack <= 0;
      ls_rd <= ~ls_rd;
    end
    if (bus_req && !bus_ack && $random(seed) % 2 == 0) begin
      if (bus_we) bus_mem[bus_addr] = bus_wd;
      bus_ack <= 1;
      bus_rd <= bus_mem[bus_addr];
    end else begin
      bus_ack <= 0;
      bus_rd <= ~bus_rd;
    end
  end
  task automatic stop_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do begin @(posedge clk_i); k++; end while (wt !== 1'b0 && k < 40);
    q = rdat;
    rd <= 0;
    wr <= 0;
    // Judge by the last sample, so an answer on the final try still counts
    if (wt !== 1'b0) begin fails++; stop_test; end
  endtask
  task automatic poll(input int b, input logic v);
    int k = 0;
    do begin av(REG_STATUS, 0, 0); k++; end while (q[b] !== v && k < 300);
    if (q[b] !== v) begin fails++; stop_test; end
  endtask
  // Clear status, load parameters, then go
  task automatic run(input logic [31:0] ct, tg, sz, ls, h, l);
    logic [31:0] v [5];
    v = '{tg, sz, ls, h, l};
    av(REG_STATUS, 1, 32'h1e);
    for (int i = 0; i < 5; i++) av(REG_TAG + 5'(4 * i), 1, v[i]);
    av(REG_CTRL, 1, ct | 32'h8000_0000);
  endtask
  // Seed the source side and queue what the destination must receive
  task automatic fill(input logic p, input logic [LS_AW-1:0] a, input logic [EA_W-1:0] r, input int n);
    for (int k = 0; k < n; k++) begin
      wv = $random(seed);
      exq.push_back(wv);
      if (p) ls_mem[a + 18'(4 * k)] = wv;
      else bus_mem[r + 64'(4 * k)] = wv;
    end
  endtask
  task automatic comp(input logic p, input logic [LS_AW-1:0] a, input logic [EA_W-1:0] r, input int n);
    for (int k = 0; k < n; k++) begin
      wv = exq.pop_front();
      if (p) `CHK(bus_mem[r + 64'(4 * k)], wv)
      else `CHK(ls_mem[a + 18'(4 * k)], wv)
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 0;
    // Single blocks, every modifier; high word ignored unless flagged
    for (int i = 0; i < 6; i++) begin
      c = MD[i];
      hi = $random(seed);
      lo = $random(seed) & 32'hffff_fffc;
      nw = 1 + ($unsigned($random(seed)) % 8);
      la = 18'h00400 + 18'(i * 64);
      ea = {c[CT_EAHV] ? hi : 32'h0, lo};
      fill(c[CT_PUT], la, ea ^ XM, nw);
      run({24'h0, c}, i, 4 * nw, la, hi, lo);
      poll(ST_BUSY, 0);
      comp(c[CT_PUT], la, ea ^ XM, nw);
      `CHK(q[ST_RUN], c[CT_START])
      `CHK(q[20:16], 5'(i))
      `CHK(q[ST_ERR], 1'b0)
    end
    $display("single block tests done");
    // Gather then scatter; first element crosses the 4 GB line; stall first, then last
    for (int p = 0; p < 2; p++) begin
      hi = $random(seed);
      lo = $random(seed) & 32'hffff_fffc;
      lst = 18'h02000 + 18'(p * 64);
      la = 18'h03000 + 18'(p * 256);
      ls_mem[lst] = {p == 0, 16'h0, 15'h0008};
      ls_mem[lst + 18'h4] = 32'hffff_fffc;
      ls_mem[lst + 18'h8] = {p == 1, 16'h0, 15'h000c};
      ls_mem[lst + 18'hc] = lo;
      fill(p[0], la, {hi, 32'hffff_fffc} ^ XM, 2);
      fill(p[0], la + 18'h8, {hi, lo} ^ XM, 3);
      run(32'h82 | p | (p ? 32'h4 : 32'h8), 9 + p, 16, la, hi, lst);
      if (p == 0) begin
        poll(ST_STALL, 1);
        `CHK(q[12:8], 5'd9)
        `CHK(q[ST_BUSY], 1'b1)
        av(REG_STATUS, 1, 32'h8);
      end
      poll(ST_BUSY, 0);
      `CHK(q[ST_STALL], 1'b0)
      `CHK(q[ST_ERR], 1'b0)
      comp(p[0], la, {hi, 32'hffff_fffc} ^ XM, 2);
      comp(p[0], la + 18'h8, {hi, lo} ^ XM, 3);
    end
    $display("list tests done");
    // Refused: start from local queue, list from proxy, list size not a multiple of 8
    for (int i = 0; i < 3; i++) begin
      run({24'h0, RJ[i]}, 3, 4 + 4 * i, 18'h0, 0, 32'h2000);
      av(REG_STATUS, 0, 0);
      `CHK(q[ST_REJ], 1'b1)
    end
    av(5'h1c, 0, 0);
    `CHK(q, 32'h0)
    $display("refusal tests done");
    stop_test;
  end
  initial begin
    #2500000;
    fails++;
    stop_test;
  end
endmodule // dgpl_tb
